//--- src/cicac_top.sv
// Contract
// [RQ1] power-up request: wake-up, then U2
// [RQ2] synced reports sum indication; U3 gives U4H, through
// [RQ3] analog loop: local loopback, pseudo wake-up, U2
// [RQ4] loop two: activation with positive M symbol
// [RQ5] repeater loop: activation with +/0 M symbol
// [RQ6] shutdown: send U0, ignore wake-up, confirm later
// [RQ7] confirm command powers down, wake-up stays armed
// [RQ8] controller may force shutdown by confirm command
// [RQ9] reinit command returns channel to initial state
// [RQ10] single pulses every 1 ms, alternating polarity
// [RQ11] test: through-connect without wake-up
// [RQ12] termination disable: silent until reinit/shutdown/confirm
// [RQ13] controller follows reinit/shutdown with confirm
// [RQ14] line wake-up powers up, reports activate
// [RQ15] loop and power-up commands acknowledged with activate; loop two accepted in a linked state keeps the current indication
// [RQ16] connected-through once activation completes
// [RQ17] deactivating: shutdown indication, U0 or pulses
// [RQ18] confirm indication after incoming signal disappears
// [RQ19] framing lost: resync indication, stay through
// [RQ20] command acts after two identical frames
// [RQ21] unlisted codes ignored, impossible commands ignored
// [RQ22] indication sent every frame, only listed codes
// [RQ23] per-channel filter, state machine and timeslot
`timescale 1ns/100ps
`default_nettype none

module cicac_top #(
  parameter int NCH       = 4,
  parameter int PULSE_CYC = cicac_pkg::PULSE_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [3:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_bus_clk,
  input  wire logic              i_bus_fsync,
  input  wire logic              i_bus_din,
  output logic                   o_bus_dout,
  input  wire logic [NCH-1:0]    i_wakeup_det,
  input  wire logic [NCH-1:0]    i_wakeup_ok,
  input  wire logic [NCH-1:0]    i_rx_sync,
  input  wire logic [NCH-1:0]    i_info_u3,
  input  wire logic [NCH-1:0]    i_frame_lost,
  input  wire logic [NCH-1:0]    i_signal_lost,
  output logic      [NCH-1:0]    o_power_up,
  output logic      [NCH-1:0]    o_through,
  output logic      [3*NCH-1:0]  o_tx_info,
  output logic      [2*NCH-1:0]  o_loop_mode,
  output logic      [NCH-1:0]    o_pulse,
  output logic      [NCH-1:0]    o_pulse_pol
);

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = cicac_pkg::SLOTS_PER_FRAME *
                              cicac_pkg::SLOT_BITS;
  localparam int POS_W = $clog2(FRAME_BITS);
  localparam int CH_W  = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int PCW   = $clog2(PULSE_CYC + 1);
  localparam logic [POS_W-1:0] POS_LAST   = POS_W'(FRAME_BITS - 1);
  localparam logic [POS_W-1:0] SLOT_B     = POS_W'(cicac_pkg::SLOT_BITS);
  localparam logic [POS_W-1:0] CI_FIRST   =
    POS_W'(cicac_pkg::CI_FIRST_BIT);
  localparam logic [POS_W-1:0] CI_LAST    =
    POS_W'(cicac_pkg::CI_FIRST_BIT + cicac_pkg::CI_BITS - 1);
  localparam logic [POS_W-1:0] NCH_P      = POS_W'(NCH);
  localparam logic [PCW-1:0]   PULSE_LAST = PCW'(PULSE_CYC - 1);

  if (NCH < 1 || NCH > 8 || 2 * NCH > cicac_pkg::SLOTS_PER_FRAME)
  begin : g_bad_nch
    $error("cicac_top: NCH out of range");
  end
  if (PULSE_CYC < 2) begin : g_bad_pulse
    $error("cicac_top: PULSE_CYC too small");
  end

  // ----------------------------------------------------------------
  // bus pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] clk_sy_r;
  logic [1:0] fs_sy_r;
  logic [1:0] din_sy_r;
  logic       clk_d_r;

  always_ff @(posedge i_clk) begin
    clk_sy_r <= {clk_sy_r[0], i_bus_clk};
    fs_sy_r  <= {fs_sy_r[0], i_bus_fsync};
    din_sy_r <= {din_sy_r[0], i_bus_din};
    // no reset value: a forced low would fake a rise after reset
    clk_d_r  <= clk_sy_r[1];
  end

  wire bus_rise = clk_sy_r[1] & ~clk_d_r;
  wire bus_fall = ~clk_sy_r[1] & clk_d_r;

  // ----------------------------------------------------------------
  // frame position and timeslot decode
  // ----------------------------------------------------------------
  logic [1:0]       ctrl_r;
  logic [POS_W-1:0] pos_r;

  wire              enable  = ctrl_r[cicac_pkg::CTRL_ENABLE_BIT];
  wire [POS_W-1:0]  base    =
    ctrl_r[cicac_pkg::CTRL_BANK_BIT] ? NCH_P : '0;
  wire [POS_W-1:0]  pos_inc = (pos_r == POS_LAST) ? '0 : pos_r + 1'b1;
  // frame sync restarts the count, so a slipped frame realigns at once
  wire [POS_W-1:0]  rx_pos  = fs_sy_r[1] ? '0 : pos_inc;
  wire [POS_W-1:0]  rx_bit  = rx_pos % SLOT_B;
  wire [POS_W-1:0]  rx_slot = rx_pos / SLOT_B;
  wire [POS_W-1:0]  rx_rel  = rx_slot - base;
  wire              rx_own  = (rx_slot >= base) &&
                              (rx_slot < base + NCH_P);
  wire              rx_ci   = (rx_bit >= CI_FIRST) &&
                              (rx_bit <= CI_LAST);
  // the next bit goes out on the falling edge, ready for the next rise
  wire [POS_W-1:0]  tx_bit  = pos_inc % SLOT_B;
  wire [POS_W-1:0]  tx_slot = pos_inc / SLOT_B;
  wire [POS_W-1:0]  tx_rel  = tx_slot - base;
  wire              tx_own  = (tx_slot >= base) &&
                              (tx_slot < base + NCH_P);
  wire              tx_ci   = (tx_bit >= CI_FIRST) &&
                              (tx_bit <= CI_LAST);
  wire [1:0]        tx_sel  = 2'(CI_LAST - tx_bit);

  // ----------------------------------------------------------------
  // command capture per timeslot
  // ----------------------------------------------------------------
  logic [3:0]      ci_sh_r;
  logic            cmd_stb_r;
  logic [CH_W-1:0] cmd_ch_r;
  logic [3:0]      cmd_code_r;
  logic            dout_r;
  logic [4*NCH-1:0] ind_flat;

  wire [3:0] ci_word = {ci_sh_r[2:0], din_sy_r[1]};
  wire [3:0] tx_code = ind_flat[CH_W'(tx_rel) * 4 +: 4];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pos_r      <= POS_LAST;
      ci_sh_r    <= 4'h0;
      cmd_stb_r  <= 1'b0;
      cmd_ch_r   <= '0;
      cmd_code_r <= 4'h0;
    end else begin
      cmd_stb_r <= 1'b0;
      if (bus_rise) begin
        pos_r <= rx_pos;
        if (rx_ci)
          ci_sh_r <= ci_word;
        if (rx_ci && rx_bit == CI_LAST && rx_own && enable) begin // [RQ23]
          cmd_stb_r  <= 1'b1;
          cmd_ch_r   <= CH_W'(rx_rel);
          cmd_code_r <= ci_word;
        end
      end
    end
  end

  // idle bits and foreign slots stay high so another device can share
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      dout_r <= 1'b1;
    else if (bus_fall)
      dout_r <= (tx_ci && tx_own && enable) ? tx_code[tx_sel]
                                            : 1'b1; // [RQ22] [RQ23]
  end

  // ----------------------------------------------------------------
  // shared 1 ms tick for single pulses
  // ----------------------------------------------------------------
  logic [PCW-1:0] tick_cnt_r;
  logic           tick_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == PULSE_LAST); // [RQ10]
      tick_cnt_r <= (tick_cnt_r == PULSE_LAST) ? '0
                                               : tick_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel filter and activation state machine
  // ----------------------------------------------------------------
  logic [4*NCH-1:0] acc_flat;
  logic [NCH-1:0]   pwr_vec;
  logic [NCH-1:0]   thr_vec;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    cicac_pkg::cicac_state_t st_r, st_nxt;
    cicac_pkg::cicac_loop_t  loop_r, loop_nxt;
    logic [3:0]              prev_r;
    logic [3:0]              acc_r;
    logic [3:0]              ind_r;
    logic                    pwr_r;
    logic                    thr_r;
    logic [2:0]              tx_r;
    logic                    pls_r;
    logic                    pol_r;
    logic                    cmd_ok;
    logic [3:0]              ind_nxt;
    cicac_pkg::cicac_tx_t    tx_nxt;

    wire mine   = cmd_stb_r && (cmd_ch_r == CH_W'(g));
    wire [3:0] c = cmd_code_r;
    wire listed = (c == cicac_pkg::CMD_SHUTDOWN)      ||
                  (c == cicac_pkg::CMD_TERM_DISABLE)  ||
                  (c == cicac_pkg::CMD_SINGLE_PULSE)  ||
                  (c == cicac_pkg::CMD_TEST)          ||
                  (c == cicac_pkg::CMD_POWER_UP)      ||
                  (c == cicac_pkg::CMD_ANALOG_LOOP)   ||
                  (c == cicac_pkg::CMD_FAR_LOOP_TWO)  ||
                  (c == cicac_pkg::CMD_REPEATER_LOOP) ||
                  (c == cicac_pkg::CMD_REINIT)        ||
                  (c == cicac_pkg::CMD_CONFIRM);
    // an ignored command stays pending and acts once the state allows
    wire new_cmd = mine && (c == prev_r) && (c != acc_r)
                   && listed; // [RQ20] [RQ21]
    wire idle   = (st_r == cicac_pkg::ST_DOWN) ||
                  (st_r == cicac_pkg::ST_CONFIRMED);
    wire linked = (st_r == cicac_pkg::ST_SYNC) ||
                  (st_r == cicac_pkg::ST_SYNCED) ||
                  (st_r == cicac_pkg::ST_ACTIVE) ||
                  (st_r == cicac_pkg::ST_RESYNC);
    wire locked = (st_r == cicac_pkg::ST_TERM_OFF);

    always_comb begin
      st_nxt   = st_r;
      loop_nxt = loop_r;
      cmd_ok   = 1'b0;
      if (new_cmd) begin
        unique case (c)
          cicac_pkg::CMD_POWER_UP: if (idle) begin // [RQ1] [RQ15]
            st_nxt   = cicac_pkg::ST_WAKE;
            loop_nxt = cicac_pkg::LOOP_NONE;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_ANALOG_LOOP: if (idle) begin // [RQ3] [RQ15]
            st_nxt   = cicac_pkg::ST_WAKE;
            loop_nxt = cicac_pkg::LOOP_ANALOG;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_FAR_LOOP_TWO: if (idle || linked) begin // [RQ4]
            st_nxt   = idle ? cicac_pkg::ST_WAKE : st_r;
            loop_nxt = cicac_pkg::LOOP_FAR_TWO;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_REPEATER_LOOP: if (idle) begin // [RQ5] [RQ15]
            st_nxt   = cicac_pkg::ST_WAKE;
            loop_nxt = cicac_pkg::LOOP_REPEATER;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_SHUTDOWN: if (!idle) begin // [RQ6] [RQ12]
            st_nxt   = locked ? cicac_pkg::ST_DOWN : cicac_pkg::ST_DEACT;
            loop_nxt = cicac_pkg::LOOP_NONE;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_CONFIRM: begin // [RQ7] [RQ8] [RQ12]
            st_nxt   = cicac_pkg::ST_DOWN;
            loop_nxt = cicac_pkg::LOOP_NONE;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_REINIT: begin // [RQ9] [RQ12]
            st_nxt   = cicac_pkg::ST_DOWN;
            loop_nxt = cicac_pkg::LOOP_NONE;
            cmd_ok   = 1'b1;
          end
          cicac_pkg::CMD_SINGLE_PULSE:
            if (idle || st_r == cicac_pkg::ST_DEACT) begin // [RQ10]
              st_nxt   = cicac_pkg::ST_PULSE;
              loop_nxt = cicac_pkg::LOOP_NONE;
              cmd_ok   = 1'b1;
            end
          cicac_pkg::CMD_TEST:
            if (st_r == cicac_pkg::ST_DOWN) begin // [RQ11]
              st_nxt = cicac_pkg::ST_TEST;
              cmd_ok = 1'b1;
            end
          cicac_pkg::CMD_TERM_DISABLE: begin // [RQ12]
            st_nxt   = cicac_pkg::ST_TERM_OFF;
            loop_nxt = cicac_pkg::LOOP_NONE;
            cmd_ok   = 1'b1;
          end
          default: ;
        endcase
      end
      if (!cmd_ok) begin
        unique case (st_r)
          cicac_pkg::ST_DOWN: if (i_wakeup_det[g]) begin // [RQ7] [RQ14]
            st_nxt   = cicac_pkg::ST_WAKE;
            loop_nxt = cicac_pkg::LOOP_NONE;
          end
          cicac_pkg::ST_WAKE:
            if (i_wakeup_ok[g]) st_nxt = cicac_pkg::ST_SYNC; // [RQ1]
          cicac_pkg::ST_SYNC:
            if (i_rx_sync[g]) st_nxt = cicac_pkg::ST_SYNCED; // [RQ2]
          cicac_pkg::ST_SYNCED:
            if (i_info_u3[g]) st_nxt = cicac_pkg::ST_ACTIVE; // [RQ2]
          cicac_pkg::ST_ACTIVE:
            if (i_frame_lost[g]) st_nxt = cicac_pkg::ST_RESYNC; // [RQ19]
          cicac_pkg::ST_RESYNC:
            if (i_rx_sync[g]) st_nxt = cicac_pkg::ST_ACTIVE; // [RQ19]
          cicac_pkg::ST_DEACT: // [RQ18]
            if (i_signal_lost[g]) st_nxt = cicac_pkg::ST_CONFIRMED;
          default: ;
        endcase
      end
    end

    // line signal and indication follow the next state
    always_comb begin
      ind_nxt = cicac_pkg::IND_CONFIRM;
      tx_nxt  = cicac_pkg::TX_SILENT;
      unique case (st_nxt)
        cicac_pkg::ST_DOWN: begin
          ind_nxt = cicac_pkg::IND_CONFIRM;
          tx_nxt  = cicac_pkg::TX_SILENT; // [RQ7]
        end
        cicac_pkg::ST_WAKE: begin
          ind_nxt = cicac_pkg::IND_POWER_UP; // [RQ14] [RQ15]
          tx_nxt  = cicac_pkg::TX_U2W; // [RQ1] [RQ3]
        end
        cicac_pkg::ST_SYNC: begin
          ind_nxt = cicac_pkg::IND_POWER_UP;
          tx_nxt  = cicac_pkg::TX_U2; // [RQ1] [RQ3]
        end
        cicac_pkg::ST_SYNCED: begin
          ind_nxt = cicac_pkg::IND_RX_SYNCED; // [RQ2]
          tx_nxt  = cicac_pkg::TX_U2;
        end
        cicac_pkg::ST_ACTIVE, cicac_pkg::ST_TEST: begin
          ind_nxt = cicac_pkg::IND_CONNECTED; // [RQ16]
          tx_nxt  = cicac_pkg::TX_U4H; // [RQ2] [RQ11]
        end
        cicac_pkg::ST_RESYNC: begin
          ind_nxt = cicac_pkg::IND_FRAMING_LOST; // [RQ19]
          tx_nxt  = cicac_pkg::TX_U4H;
        end
        cicac_pkg::ST_DEACT: begin
          ind_nxt = cicac_pkg::IND_SHUTDOWN; // [RQ17]
          tx_nxt  = cicac_pkg::TX_U0; // [RQ6]
        end
        cicac_pkg::ST_CONFIRMED: begin
          ind_nxt = cicac_pkg::IND_CONFIRM; // [RQ6] [RQ18]
          tx_nxt  = cicac_pkg::TX_U0;
        end
        cicac_pkg::ST_TERM_OFF: begin
          ind_nxt = cicac_pkg::IND_SHUTDOWN;
          tx_nxt  = cicac_pkg::TX_SILENT; // [RQ12]
        end
        cicac_pkg::ST_PULSE: begin
          ind_nxt = cicac_pkg::IND_SHUTDOWN; // [RQ17]
          tx_nxt  = cicac_pkg::TX_PULSE; // [RQ10]
        end
        default: ;
      endcase
    end

    wire pwr_nxt = (st_nxt != cicac_pkg::ST_DOWN); // [RQ7]
    wire thr_nxt = (st_nxt == cicac_pkg::ST_ACTIVE) ||
                   (st_nxt == cicac_pkg::ST_RESYNC) ||
                   (st_nxt == cicac_pkg::ST_TEST); // [RQ2] [RQ11] [RQ19]
    // no pulse in the cycle that leaves the pulse state
    wire in_pulse = (st_r == cicac_pkg::ST_PULSE) &&
                    (st_nxt == cicac_pkg::ST_PULSE);

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        st_r   <= cicac_pkg::ST_DOWN;
        loop_r <= cicac_pkg::LOOP_NONE;
        prev_r <= cicac_pkg::CMD_CONFIRM;
        acc_r  <= cicac_pkg::CMD_CONFIRM;
        ind_r  <= cicac_pkg::IND_CONFIRM;
        pwr_r  <= 1'b0;
        thr_r  <= 1'b0;
        tx_r   <= cicac_pkg::TX_SILENT;
      end else begin
        st_r   <= st_nxt;
        loop_r <= loop_nxt;
        ind_r  <= ind_nxt; // [RQ22]
        pwr_r  <= pwr_nxt;
        thr_r  <= thr_nxt;
        tx_r   <= tx_nxt;
        if (mine)
          prev_r <= c; // [RQ20]
        if (cmd_ok)
          acc_r <= c; // [RQ21]
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        pls_r <= 1'b0;
        pol_r <= 1'b0;
      end else begin
        pls_r <= in_pulse && tick_r; // [RQ10]
        if (in_pulse && tick_r)
          pol_r <= ~pol_r; // [RQ10]
      end
    end

    assign ind_flat[4*g +: 4]    = ind_r;
    assign acc_flat[4*g +: 4]    = acc_r;
    assign pwr_vec[g]            = pwr_r;
    assign thr_vec[g]            = thr_r;
    assign o_power_up[g]         = pwr_r;
    assign o_through[g]          = thr_r;
    assign o_tx_info[3*g +: 3]   = tx_r;
    assign o_loop_mode[2*g +: 2] = loop_r; // [RQ3] [RQ4] [RQ5]
    assign o_pulse[g]            = pls_r;
    assign o_pulse_pol[g]        = pol_r;
  end

  // ----------------------------------------------------------------
  // avalon-mm slave, one wait state per access
  // ----------------------------------------------------------------
  logic        wait_r;
  logic [31:0] rdata_r;

  wire req      = i_avs_read | i_avs_write;
  wire take     = req & wait_r;
  wire hit_ctrl = (i_avs_address == cicac_pkg::REG_CTRL);
  wire [31:0] status_word =
    32'({thr_vec, {(cicac_pkg::STATUS_THRU_POS - NCH){1'b0}}, pwr_vec});
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, ctrl_r} :
    (i_avs_address == cicac_pkg::REG_ACCEPTED)   ? 32'(acc_flat) :
    (i_avs_address == cicac_pkg::REG_INDICATION) ? 32'(ind_flat) :
    (i_avs_address == cicac_pkg::REG_STATUS)     ? status_word :
    32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r  <= cicac_pkg::CTRL_RESET;
    end else begin
      wait_r <= ~take;
      if (take && i_avs_read)
        rdata_r <= rd_mux;
      if (!wait_r && i_avs_write && hit_ctrl && i_avs_byteenable[0])
        ctrl_r <= i_avs_writedata[1:0];
    end
  end

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_bus_dout        = dout_r;

endmodule : cicac_top

`default_nettype wire

//--- src/cicac_pkg.sv
package cicac_pkg;

  // ----------------------------------------------------------------
  // command codes from the controller
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_SHUTDOWN      = 4'h0;
  localparam logic [3:0] CMD_TERM_DISABLE  = 4'h3;
  localparam logic [3:0] CMD_SINGLE_PULSE  = 4'h5;
  localparam logic [3:0] CMD_TEST          = 4'h6;
  localparam logic [3:0] CMD_POWER_UP      = 4'h8;
  localparam logic [3:0] CMD_ANALOG_LOOP   = 4'h9;
  localparam logic [3:0] CMD_FAR_LOOP_TWO  = 4'hA;
  localparam logic [3:0] CMD_REPEATER_LOOP = 4'hB;
  localparam logic [3:0] CMD_REINIT        = 4'hD;
  localparam logic [3:0] CMD_CONFIRM       = 4'hF;

  // ----------------------------------------------------------------
  // indication codes toward the controller
  // ----------------------------------------------------------------
  localparam logic [3:0] IND_SHUTDOWN      = 4'h1;
  localparam logic [3:0] IND_FRAMING_LOST  = 4'h4;
  localparam logic [3:0] IND_RX_SYNCED     = 4'h7;
  localparam logic [3:0] IND_POWER_UP      = 4'h8;
  localparam logic [3:0] IND_CONNECTED     = 4'hC;
  localparam logic [3:0] IND_CONFIRM       = 4'hF;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_ACCEPTED     = 4'h4;
  localparam logic [3:0]  REG_INDICATION   = 4'h8;
  localparam logic [3:0]  REG_STATUS       = 4'hC;
  localparam int          CTRL_ENABLE_BIT  = 0;
  localparam int          CTRL_BANK_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;
  localparam int          STATUS_THRU_POS  = 8;

  // ----------------------------------------------------------------
  // serial frame layout and timing
  // ----------------------------------------------------------------
  localparam int SLOTS_PER_FRAME = 8;
  localparam int SLOT_BITS       = 32;
  localparam int CI_FIRST_BIT    = 26;
  localparam int CI_BITS         = 4;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_PERIOD_NS = 1_000_000;
  localparam int PULSE_CYC       = PULSE_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_DOWN, ST_WAKE, ST_SYNC, ST_SYNCED, ST_ACTIVE, ST_RESYNC,
    ST_DEACT, ST_CONFIRMED, ST_TEST, ST_TERM_OFF, ST_PULSE
  } cicac_state_t;

  typedef enum logic [2:0] {
    TX_SILENT, TX_U0, TX_U2W, TX_U2, TX_U4H, TX_PULSE
  } cicac_tx_t;

  typedef enum logic [1:0] {
    LOOP_NONE, LOOP_ANALOG, LOOP_FAR_TWO, LOOP_REPEATER
  } cicac_loop_t;

endpackage : cicac_pkg

//--- verification/cicac_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cicac_checker #(
  parameter int NCH = 4
) (
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  input wire logic             i_avs_read,
  input wire logic             i_avs_write,
  input wire logic             o_avs_waitrequest,
  input wire logic [NCH-1:0]   i_wakeup_ok,
  input wire logic [NCH-1:0]   i_frame_lost,
  input wire logic [NCH-1:0]   o_power_up,
  input wire logic [NCH-1:0]   o_through,
  input wire logic [3*NCH-1:0] o_tx_info,
  input wire logic [NCH-1:0]   o_pulse,
  input wire logic [NCH-1:0]   o_pulse_pol
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // channel checks cover channel 0 only, as the bench exercises that channel; the first check is on the bus
  ack_one_cycle_a: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest low not one cycle");
  wake_powered_a: assert property (
    o_tx_info[2:0] == 3'h2 |-> o_power_up[0])
    else $error("wake-up sent while unpowered");
  wake_to_sync_a: assert property (
    o_tx_info[2:0] == 3'h2 && i_wakeup_ok[0]
    |-> ##[1:3] o_tx_info[2:0] == 3'h3) else $error("no sync after wake-up");
  u4h_through_a: assert property (o_tx_info[2:0] == 3'h4 &&
    $past(o_tx_info[2:0]) == 3'h4 |-> o_through[0])
    else $error("u4h without through");
  u0_not_thru_a: assert property (
    o_tx_info[2:0] == 3'h1 |-> !o_through[0])
    else $error("through while deactivating");
  resync_thru_a: assert property (o_through[0] && i_frame_lost[0] |=>
    o_through[0]) else $error("through dropped on framing loss");
  pulse_state_a: assert property (
    o_pulse[0] |-> o_tx_info[2:0] == 3'h5)
    else $error("pulse outside pulse mode");
  pulse_gap_a: assert property (o_pulse[0] |=> !o_pulse[0] [*8])
    else $error("pulses too close");
  pol_toggle_a: assert property (o_pulse[0] |->
    o_pulse_pol[0] != $past(o_pulse_pol[0])) else $error("polarity kept");
endmodule : cicac_checker
bind cicac_top cicac_checker #(.NCH(NCH)) cicac_checker_inst (.i_clk,
  .i_rst_n, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_wakeup_ok,
  .i_frame_lost, .o_power_up, .o_through, .o_tx_info, .o_pulse,
  .o_pulse_pol);
`default_nettype wire

//--- verification/cicac_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module cicac_ctrl_model (
  output logic      o_bus_clk,
  output logic      o_bus_fsync,
  output logic      o_bus_din,
  input  wire logic i_bus_dout
);
  logic [3:0] cmd [8];
  logic [3:0] ind [8];
  logic [7:0] pos;
  logic [7:0] nx;
  assign nx = pos + 8'h01;
  initial begin
    o_bus_clk = 1'b0;
    o_bus_fsync = 1'b0;
    o_bus_din = 1'b1;
    pos = 8'hFF;
    foreach (cmd[k]) cmd[k] = 4'hF;
  end
  // runs free: the device takes its frame and bit timing from this clock, the 1 ms tick from i_clk
  always #40 o_bus_clk = ~o_bus_clk;
  // drive on the fall so every bit is settled at the sampling rise
  always @(negedge o_bus_clk) begin
    if (pos[4:0] inside {[5'h1A:5'h1D]})
      ind[pos[7:5]] <= {ind[pos[7:5]][2:0], i_bus_dout};
    pos <= nx;
    o_bus_fsync <= (nx == 8'h00);
    o_bus_din <= (nx[4:0] inside {[5'h1A:5'h1D]}) ?
      cmd[nx[7:5]][5'h1D - nx[4:0]] : 1'b1;
  end
endmodule : cicac_ctrl_model
`default_nettype wire

//--- verification/tb_ci_channel_activation_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ci_channel_activation_control;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [5:0]  ev = 6'h00;
  logic [31:0] rdata, q, a;
  logic [23:0] r;
  logic        wq, bclk, fs, din, dout;
  logic [3:0]  pw, thr, pl, pp;
  logic [11:0] tx;
  logic [7:0]  lm;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] n;
  // {cmd, events, indication, tx (F: any), through, 0, loop}
  logic [23:0] rows [24] = '{24'h80_0820, 24'h80_2830, 24'h80_6730,
    24'h80_EC48, 24'h81_A448, 24'h00_E110, 24'h02_0FF0,
    24'hF0_0F00, 24'hF0_1820, 24'hD0_0F00, 24'hA0_0822,
    24'hD0_0F00, 24'hB0_0823, 24'hD0_0F00, 24'h90_0821,
    24'h90_2831, 24'hD0_0F00, 24'h60_0CF8, 24'hD0_0F00,
    24'h30_0100, 24'h30_1100, 24'h00_0F00, 24'hF0_0F00,
    24'h50_0150};
  cicac_ctrl_model ctrl (.o_bus_clk(bclk), .o_bus_fsync(fs),
    .o_bus_din(din), .i_bus_dout(dout));
  cicac_top #(.PULSE_CYC(50)) cicac_top_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wq), .i_bus_clk(bclk), .i_bus_fsync(fs),
    .i_bus_din(din), .o_bus_dout(dout), .i_wakeup_det({3'h0, ev[0]}),
    .i_wakeup_ok({3'h0, ev[1]}), .i_rx_sync({3'h0, ev[2]}),
    .i_info_u3({3'h0, ev[3]}), .i_frame_lost({3'h0, ev[4]}),
    .i_signal_lost({3'h0, ev[5]}), .o_power_up(pw), .o_through(thr),
    .o_tx_info(tx), .o_loop_mode(lm), .o_pulse(pl), .o_pulse_pol(pp));
  always #5 clk = ~clk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // request holds until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
           output logic [31:0] o);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    o = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // idle edge so a following call never re-raises in this step
    @(posedge clk);
  endtask : bus
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // read-only and unmapped places ignore writes
    bus(1'b1, 4'h4, 32'h0000_0000, q);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
    bus(1'b0, 4'h0, 32'h0000_0000, q); cmp(q, 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0000, q); cmp(q, 32'h0000_FFFF);
    bus(1'b0, 4'h8, 32'h0000_0000, q); cmp(q, 32'h0000_FFFF);
    bus(1'b0, 4'hC, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000, q); cmp(q, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0001, q);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      ctrl.cmd[0] = r[23:20];
      ev <= r[17:12];
      repeat (4) @(posedge clk);
      n = 0;
      do begin
        bus(1'b0, 4'h4, 32'h0000_0000, a);
        bus(1'b0, 4'h8, 32'h0000_0000, q);
        n++;
      end while ((a[3:0] !== r[23:20] || q[3:0] !== r[11:8]) && n < 4000);
      cmp(q[7:0], {4'hF, r[11:8]});
      if (r[7:4] != 4'hF) cmp(tx[2:0], r[6:4]);
      cmp({thr[0], lm[1:0]}, {r[3], r[1:0]});
      $display("row %0d done", i);
    end
    n = 0;
    repeat (200) begin
      @(negedge clk);
      n += pl[0];
    end
    cmp(n, 4);
    // one frame of a new code, then an unlisted code
    wait (ctrl.pos == 8'h28);
    ctrl.cmd[0] = 4'h8;
    repeat (2048) @(posedge clk);
    ctrl.cmd[0] = 4'h2;
    repeat (4200) @(posedge clk);
    bus(1'b0, 4'h4, 32'h0000_0000, a);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    cmp({a[3:0], q[3:0]}, 8'h51);
    wait (ctrl.pos == 8'h64);
    cmp({ctrl.ind[1], ctrl.ind[0]}, q[7:0]);
    // bank one: channel 0 moves to slot 4, slot 0 idles high
    ctrl.cmd[4] = 4'h5;
    @(posedge clk);
    bus(1'b1, 4'h0, 32'h0000_0003, q);
    repeat (2300) @(posedge clk);
    cmp({ctrl.ind[4], ctrl.ind[0]}, 8'h1F);
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    repeat (2300) @(posedge clk);
    cmp({ctrl.ind[4], ctrl.ind[0]}, 8'hFF);
    $display("awkward tests done");
    stop_test();
  end
endmodule : tb_ci_channel_activation_control
`default_nettype wire
